// >>> rtl/bpe_burst_engine.sv
// Burst engine of a multiplexed synchronous pseudo-static RAM
`timescale 1ns/1ps
module bpe_burst_engine #(
  parameter int MEM_AW = 8
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        standby_select_i,
  input  wire logic        addr_valid_strobe_n_i,
  input  wire logic        write_enable_n_i,
  input  wire logic [31:0] adq_i,
  output logic      [31:0] adq_o,
  output logic             adq_oe_o,
  output logic             wait_n_o,
  input  wire logic [2:0]  read_latency_setting_i,
  input  wire logic [1:0]  refresh_density_i
);

  localparam int AW = bpe_pkg::ADDR_W;
  localparam int DW = bpe_pkg::DATA_W;
  localparam int IW = bpe_pkg::IDX_W;
  localparam int BW = bpe_pkg::BEAT_W;
  localparam int LW = bpe_pkg::LAT_W;

  bpe_pkg::bpe_state_e state_q;
  bpe_pkg::bpe_cmd_s   cmd_q;
  logic [LW-1:0]       rd_lat_q;
  logic [LW-1:0]       cnt_q;
  logic [BW-1:0]       beat_q;
  logic [BW-1:0]       fetch_q;
  logic                strobe_prev_q;
  logic                stby_prev_q;
  logic                wait_n_q;
  logic                oe_q;
  logic [DW-1:0]       adq_q;

  logic                latch;
  logic                stby_fall;
  logic [LW-1:0]       first_edge;
  logic                beat_go;
  logic                rd_beat;
  logic                mem_we;
  logic [IW-1:0]       xfer_idx;
  logic [IW-1:0]       fetch_idx;
  logic                issue;
  logic [2:0]          occ;
  logic [DW-1:0]       mem_rdata;
  logic                mem_rvalid;
  logic                buf_in_ready;
  logic                buf_valid;
  logic [DW-1:0]       buf_data;
  logic [1:0]          buf_level;
  logic [AW-1:0]       keep_limit;

  function automatic logic [LW-1:0] lat_cycles(input logic [2:0] code);
    case (code)
      bpe_pkg::LAT_CODE_6: return bpe_pkg::RD_LAT_6;
      bpe_pkg::LAT_CODE_7: return bpe_pkg::RD_LAT_7;
      bpe_pkg::LAT_CODE_8: return bpe_pkg::RD_LAT_8;
      default:             return bpe_pkg::RD_LAT_8;
    endcase
  endfunction

  // A strobe held low from reset never latches: a high must be seen first
  assign latch = strobe_prev_q && !addr_valid_strobe_n_i && // R17
                 !chip_select_n_i && standby_select_i;
  assign stby_fall = stby_prev_q && !standby_select_i;

  // Writes begin one edge before reads for the same setting
  assign first_edge = cmd_q.write ? rd_lat_q - bpe_pkg::WL_OFFSET // R6
                                  : rd_lat_q;

  // Reads also need a word waiting; the prefetch keeps one ready
  assign beat_go = !latch && !chip_select_n_i && wait_n_q && // R19
                   (cmd_q.write || buf_valid) &&
                   ((state_q == bpe_pkg::ST_PREP && cnt_q == first_edge) ||
                    (state_q == bpe_pkg::ST_XFER &&
                     beat_q != bpe_pkg::BURST_LEN)); // R9
  assign rd_beat  = beat_go && !cmd_q.write;
  assign mem_we   = beat_go && cmd_q.write; // R12 R13
  assign xfer_idx  = cmd_q.addr[IW-1:0] + beat_q[IW-1:0]; // R3
  assign fetch_idx = cmd_q.addr[IW-1:0] + fetch_q[IW-1:0]; // R3

  // Reserve buffer room for the word already in flight from memory
  assign occ   = {1'b0, buf_level} + {2'b00, mem_rvalid} - {2'b00, rd_beat};
  assign issue = !latch && state_q != bpe_pkg::ST_IDLE && !cmd_q.write &&
                 fetch_q != bpe_pkg::BURST_LEN && occ < 3'h2; // R2

  always_comb begin
    case (refresh_density_i)
      bpe_pkg::PR_64M: keep_limit = bpe_pkg::LIM_64M;
      bpe_pkg::PR_32M: keep_limit = bpe_pkg::LIM_32M;
      bpe_pkg::PR_16M: keep_limit = bpe_pkg::LIM_16M;
      default:         keep_limit = '0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobe_prev_q <= 1'b0;
      stby_prev_q   <= 1'b1;
    end else begin
      strobe_prev_q <= addr_valid_strobe_n_i;
      stby_prev_q   <= standby_select_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_q    <= '0;
      rd_lat_q <= bpe_pkg::RD_LAT_8;
    end else if (latch) begin
      cmd_q.write <= !write_enable_n_i; // R17
      cmd_q.addr  <= adq_i[AW-1:0]; // R4
      rd_lat_q    <= lat_cycles(read_latency_setting_i); // R5
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= bpe_pkg::ST_IDLE;
    end else if (!standby_select_i) begin
      state_q <= bpe_pkg::ST_IDLE;
    end else if (latch) begin
      state_q <= bpe_pkg::ST_PREP;
    end else begin
      case (state_q)
        bpe_pkg::ST_PREP: begin
          if (chip_select_n_i) begin
            state_q <= bpe_pkg::ST_IDLE;
          end else if (beat_go) begin
            state_q <= bpe_pkg::ST_XFER;
          end
        end
        bpe_pkg::ST_XFER: begin
          if (chip_select_n_i || beat_q == bpe_pkg::BURST_LEN) begin
            state_q <= bpe_pkg::ST_IDLE; // R10 R12
          end
        end
        default: state_q <= bpe_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (latch) begin
      cnt_q <= bpe_pkg::LAT_START; // R18
    end else if (state_q == bpe_pkg::ST_PREP) begin
      cnt_q <= cnt_q + bpe_pkg::LAT_START;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      beat_q  <= '0;
      fetch_q <= '0;
    end else begin
      if (latch) begin
        beat_q <= '0;
      end else if (beat_go) begin
        beat_q <= beat_q + 4'h1; // R2
      end
      if (latch) begin
        fetch_q <= '0;
      end else if (issue) begin
        fetch_q <= fetch_q + 4'h1;
      end
    end
  end

  // Registered, so it can only move on a rising edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_n_q <= 1'b1;
    end else if (latch) begin
      wait_n_q <= 1'b0; // R14
    end else if (state_q != bpe_pkg::ST_PREP ||
                 cnt_q == first_edge - bpe_pkg::LAT_START) begin
      wait_n_q <= 1'b1; // R15 R16
    end
  end

  // Output drive drops at the edge after the eighth word or on deselect
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_q  <= 1'b0;
      adq_q <= '0;
    end else begin
      oe_q <= rd_beat; // R8 R10
      if (rd_beat) begin
        adq_q <= buf_data; // R5
      end
    end
  end

  assign adq_o    = adq_q;
  assign adq_oe_o = oe_q;
  assign wait_n_o = wait_n_q;

  bpe_mem #(
    .AW      (MEM_AW),
    .DW      (DW),
    .FULL_AW (AW)
  ) u_mem (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .we_i         (mem_we),
    .waddr_i      ({cmd_q.addr[MEM_AW-1:IW], xfer_idx}),
    .wfull_i      ({cmd_q.addr[AW-1:IW], xfer_idx}),
    .wdata_i      (adq_i),
    .re_i         (issue),
    .raddr_i      ({cmd_q.addr[MEM_AW-1:IW], fetch_idx}),
    .rdata_o      (mem_rdata),
    .rvalid_o     (mem_rvalid),
    .drop_i       (stby_fall),
    .drop_all_i   (refresh_density_i == bpe_pkg::PR_0M),
    .keep_limit_i (keep_limit)
  );

  bpe_buf2 #(
    .W (DW)
  ) u_buf (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .clear_i     (latch),
    .in_valid_i  (mem_rvalid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (mem_rdata),
    .out_valid_o (buf_valid),
    .out_ready_i (rd_beat),
    .out_data_o  (buf_data),
    .level_o     (buf_level)
  );

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_read_first_word: assert property ( // R5
    (state_q == bpe_pkg::ST_PREP && !cmd_q.write && cnt_q == rd_lat_q &&
     !chip_select_n_i && !latch) |=> adq_oe_o)
    else $error("first read word not driven at read latency");

  a_write_lat_minus: assert property ( // R6
    (state_q == bpe_pkg::ST_PREP && mem_we) |->
      cnt_q == rd_lat_q - bpe_pkg::WL_OFFSET)
    else $error("first write word not one cycle before read latency");

  a_wait_lead_one: assert property ( // R16
    (state_q == bpe_pkg::ST_PREP && beat_go) |->
      wait_n_o && !$past(wait_n_o))
    else $error("wait did not rise exactly one cycle before first word");

  a_wait_low_prep: assert property ( // R14
    (state_q == bpe_pkg::ST_PREP && cnt_q < first_edge - 5'h01) |->
      !wait_n_o)
    else $error("wait high while still preparing");

  a_float_after_8: assert property ( // R8
    (rd_beat && beat_q == 4'h7) ##1 !latch |=> !adq_oe_o)
    else $error("data still driven after eighth read word");

  a_ignore_after_8: assert property ( // R9
    (beat_q == bpe_pkg::BURST_LEN) |-> !mem_we)
    else $error("write accepted after eight words");

  a_read_term_edge: assert property ( // R10
    (adq_oe_o && chip_select_n_i) |=> !adq_oe_o)
    else $error("read not ended one edge after deselect");

  a_write_term_drop: assert property ( // R13
    chip_select_n_i |-> !mem_we)
    else $error("word written on terminating edge");

  a_wrap_order: assert property ( // R3
    (beat_go && $past(beat_go) && state_q == bpe_pkg::ST_XFER) |->
      xfer_idx == $past(xfer_idx) + 3'h1)
    else $error("burst index did not step by one with wrap");

  a_upper_fixed: assert property ( // R4
    (state_q == bpe_pkg::ST_XFER && $past(state_q) != bpe_pkg::ST_IDLE &&
     !$past(latch)) |-> $stable(cmd_q.addr))
    else $error("upper address changed during burst");

  a_latch_edge: assert property ( // R17
    latch |=> state_q == bpe_pkg::ST_PREP && cnt_q == 5'h01)
    else $error("address not latched at first edge after strobe");

  a_no_drop_word: assert property ( // R2
    mem_rvalid && !latch |-> buf_in_ready)
    else $error("fetched read word found buffer full");

  c_read_full: cover property (rd_beat && beat_q == 4'h7);
  c_write_full: cover property (mem_we && beat_q == 4'h7);
  c_read_term: cover property (adq_oe_o && chip_select_n_i &&
                               beat_q != bpe_pkg::BURST_LEN);
  c_write_term: cover property (state_q == bpe_pkg::ST_XFER &&
                                cmd_q.write && chip_select_n_i);

endmodule

// >>> rtl/bpe_pkg.sv
// Shared constants and types of the burst engine
// Notes on behaviour
// (R1) Partial standby keeps only lowest address range
// (R2) Burst moves eight words, low bits pick start
// (R3) Word index steps by one, wraps seven to zero
// (R4) Upper address bits never change within burst
// (R5) First read word after programmed latency 6-8
// (R6) First write word taken one cycle earlier
// (R7) Controller picks latency allowed at its clock
// (R8) Outputs float after eighth read word
// (R9) Write data ignored after eight words
// (R10) Chip select high ends read next edge
// (R11) Controller ends read only after first word
// (R12) Chip select high ends write next edge
// (R13) Word on terminating edge is not written
// (R14) Wait low during preparation, high when ready
// (R15) Wait changes only on rising clock edges
// (R16) Wait rises one cycle before first word
// (R17) Address latched first edge after strobe falls
// (R18) Controller counts latency from latch edge
// (R19) No transfer before wait shows ready
package bpe_pkg;

  localparam int ADDR_W  = 22;
  localparam int DATA_W  = 32;
  localparam int IDX_W   = 3;
  localparam int BEAT_W  = 4;
  localparam int LAT_W   = 5;

  localparam logic [BEAT_W-1:0] BURST_LEN = 4'h8;

  // Latency field codes and the cycle counts they select
  localparam logic [2:0]       LAT_CODE_6 = 3'h4;
  localparam logic [2:0]       LAT_CODE_7 = 3'h5;
  localparam logic [2:0]       LAT_CODE_8 = 3'h6;
  localparam logic [LAT_W-1:0] RD_LAT_6   = 5'h06;
  localparam logic [LAT_W-1:0] RD_LAT_7   = 5'h07;
  localparam logic [LAT_W-1:0] RD_LAT_8   = 5'h08;
  localparam logic [LAT_W-1:0] WL_OFFSET = 5'h01;
  localparam logic [LAT_W-1:0] LAT_START = 5'h01;

  // Retained density codes and the highest address kept by each code but PR_0M
  localparam logic [1:0]        PR_32M  = 2'h0;
  localparam logic [1:0]        PR_16M  = 2'h1;
  localparam logic [1:0]        PR_64M  = 2'h2;
  localparam logic [1:0]        PR_0M   = 2'h3;
  localparam logic [ADDR_W-1:0] LIM_64M = 22'h1f_ffff;
  localparam logic [ADDR_W-1:0] LIM_32M = 22'h0f_ffff;
  localparam logic [ADDR_W-1:0] LIM_16M = 22'h07_ffff;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
  } bpe_cmd_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PREP,
    ST_XFER
  } bpe_state_e;

endpackage

// >>> rtl/bpe_mem.sv
// Word memory with registered read and per-word retention flags
`timescale 1ns/1ps
module bpe_mem #(
  parameter int AW      = 8,
  parameter int DW      = 32,
  parameter int FULL_AW = 22
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic               we_i,
  input  wire logic [AW-1:0]      waddr_i,
  input  wire logic [DW-1:0]      wdata_i,
  input  wire logic [FULL_AW-1:0] wfull_i,
  input  wire logic               re_i,
  input  wire logic [AW-1:0]      raddr_i,
  output logic      [DW-1:0]      rdata_o,
  output logic                    rvalid_o,
  input  wire logic               drop_i,
  input  wire logic               drop_all_i,
  input  wire logic [FULL_AW-1:0] keep_limit_i
);

  localparam int DEPTH = 2 ** AW;

  // Cells alias above AW bits, so each keeps the full address it was
  // written at; standby judges retention by that, not by the cell index
  logic [DW-1:0]      mem_q [DEPTH];
  logic [FULL_AW-1:0] full_q [DEPTH];
  logic [DEPTH-1:0]   held_q;

  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_q[waddr_i]  <= wdata_i;
      full_q[waddr_i] <= wfull_i;
    end
  end

  // Words lost in standby read back as zero until rewritten
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o  <= '0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= re_i;
      if (re_i) begin
        rdata_o <= held_q[raddr_i] ? mem_q[raddr_i] : '0;
      end
    end
  end

  // A write in the same cycle as a drop keeps the word
  for (genvar i = 0; i < DEPTH; i++) begin : g_held
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        held_q[i] <= 1'b0;
      end else if (we_i && waddr_i == AW'(i)) begin
        held_q[i] <= 1'b1;
      end else if (drop_i && (drop_all_i || full_q[i] > keep_limit_i)) begin
        held_q[i] <= 1'b0; // R1
      end
    end
  end

endmodule

// >>> rtl/bpe_buf2.sv
// Two-entry buffer between memory read port and pin output
`timescale 1ns/1ps
module bpe_buf2 #(
  parameter int W = 32
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         clear_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o,
  output logic      [1:0]   level_o
);

  logic [W-1:0] slot0_q;
  logic [W-1:0] slot1_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;
  logic [1:0]   wr_idx;

  assign in_ready_o  = cnt_q != 2'h2;
  assign out_valid_o = cnt_q != 2'h0;
  assign out_data_o  = slot0_q;
  assign level_o     = cnt_q;
  assign push        = in_valid_i && in_ready_o && !clear_i;
  assign pop         = out_valid_o && out_ready_i && !clear_i;
  assign wr_idx      = cnt_q - {1'b0, pop};

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 2'h0;
    end else if (clear_i) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot0_q <= '0;
      slot1_q <= '0;
    end else begin
      if (pop) begin
        slot0_q <= slot1_q;
      end
      if (push && wr_idx == 2'h0) begin
        slot0_q <= in_data_i;
      end
      if (push && wr_idx == 2'h1) begin
        slot1_q <= in_data_i;
      end
    end
  end

endmodule

// >>> testbench/bpe_ctrl_model.sv
// Memory controller model that drives the multiplexed burst bus
`timescale 1ns/1ps
module bpe_ctrl_model (
  input  wire logic        mclk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        oe_i,
  input  wire logic        wait_n_i,
  output logic             cs_n_o,
  output logic             strobe_n_o,
  output logic             we_n_o,
  output logic      [31:0] adq_o
);
  logic [31:0] wd [10];
  logic [31:0] rd [24];
  logic        ot [24];
  logic        wt [24];

  initial begin
    cs_n_o     = 1'b1;
    strobe_n_o = 1'b1;
    we_n_o     = 1'b1;
    adq_o      = 32'h0000_0000;
  end

  // Latency is legal for the bench clock; reads end only after word one
  task automatic burst(input logic wr, input logic [21:0] a, input int lat,
                       input int n);
    int j;
    @(posedge mclk_i);
    strobe_n_o <= 1'b0;
    cs_n_o     <= 1'b0;
    we_n_o     <= ~wr;
    adq_o      <= {10'h000, a};
    @(posedge mclk_i);
    strobe_n_o <= 1'b1;
    for (int t = 1; t <= lat + 11; t++) begin
      j = wr ? t - lat + 1 : t - lat;
      // Released bus shows the inverse so a stale word never matches
      if (wr && j >= 0 && j < 10)
        adq_o <= wd[j];
      else
        adq_o <= ~adq_o;
      cs_n_o <= (j >= n && (n < 8 || j >= 10)) ? 1'b1 : 1'b0;
      @(posedge mclk_i);
      wt[t-1] = wait_n_i;
      ot[t-1] = oe_i;
      rd[t-1] = rdata_i;
    end
  endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench of the burst engine with a controller model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("Error %s expected %h seen %h", nm, e, g); \
  end \
end
module tb_top;
  logic        mclk_i;
  logic        rst_n_i;
  logic        cs_n;
  logic        stby;
  logic        strobe_n;
  logic        we_n;
  logic [31:0] adq_in;
  logic [31:0] adq_out;
  logic        oe;
  logic        wait_n;
  logic [2:0]  lat_code;
  logic [1:0]  dens;
  logic [31:0] exp_d [256];
  logic [21:0] exp_a [256];
  logic        exp_v [256];
  logic [21:0] wq [$];
  logic [2:0]  codes [5] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  logic [1:0]  dcodes [4] = '{bpe_pkg::PR_64M, bpe_pkg::PR_32M,
                              bpe_pkg::PR_16M, bpe_pkg::PR_0M};
  int          err_total = 0;
  int          tests_run = 0;
  int          cycles = 0;

  bpe_burst_engine #(.MEM_AW(8)) u_dut (
    .mclk_i                (mclk_i),
    .rst_n_i               (rst_n_i),
    .chip_select_n_i       (cs_n),
    .standby_select_i      (stby),
    .addr_valid_strobe_n_i (strobe_n),
    .write_enable_n_i      (we_n),
    .adq_i                 (adq_in),
    .adq_o                 (adq_out),
    .adq_oe_o              (oe),
    .wait_n_o              (wait_n),
    .read_latency_setting_i(lat_code),
    .refresh_density_i     (dens)
  );

  bpe_ctrl_model u_ctrl (
    .mclk_i  (mclk_i),
    .rdata_i (adq_out),
    .oe_i    (oe),
    .wait_n_i(wait_n),
    .cs_n_o  (cs_n),
    .strobe_n_o(strobe_n),
    .we_n_o  (we_n),
    .adq_o   (adq_in)
  );

  function automatic int lat(input logic [2:0] c);
    case (c)
      bpe_pkg::LAT_CODE_6: return 6;
      bpe_pkg::LAT_CODE_7: return 7;
      default: return 8;
    endcase
  endfunction

  function automatic logic [21:0] lim(input logic [1:0] d);
    case (d)
      bpe_pkg::PR_64M: return bpe_pkg::LIM_64M;
      bpe_pkg::PR_32M: return bpe_pkg::LIM_32M;
      default: return bpe_pkg::LIM_16M;
    endcase
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic run(input logic wr, input logic [21:0] a,
                     input logic [2:0] code, input int n);
    int          rdl;
    int          lw;
    logic [21:0] fa;
    logic [7:0]  ix;
    rdl = lat(code);
    lw = wr ? rdl - 1 : rdl;
    lat_code <= code;
    for (int j = 0; j < 10; j++)
      u_ctrl.wd[j] = $urandom;
    u_ctrl.burst(wr, a, rdl, n);
    `CHK("wait busy", 1'b0, u_ctrl.wt[0])
    `CHK("wait early", 1'b0, u_ctrl.wt[lw-2])
    `CHK("wait ready", 1'b1, u_ctrl.wt[lw-1])
    `CHK("oe early", 1'b0, u_ctrl.ot[rdl-1])
    for (int i = 0; i < 10; i++) begin
      fa = {a[21:3], a[2:0] + 3'(i)};
      ix = fa[7:0];
      // Only accepted words update the expected image
      if (wr && i < n && i < 8) begin
        exp_d[ix] = u_ctrl.wd[i];
        exp_a[ix] = fa;
        exp_v[ix] = 1'b1;
      end
      if (!wr && i < n) begin
        `CHK("oe word", 1'b1, u_ctrl.ot[rdl+i])
        `CHK("rdata", exp_v[ix] ? exp_d[ix] : 32'h0000_0000,
             u_ctrl.rd[rdl+i])
      end
      if (!wr && i >= n)
        `CHK("oe off", 1'b0, u_ctrl.ot[rdl+i])
    end
  endtask

  task automatic standby(input logic [1:0] d);
    dens <= d;
    @(posedge mclk_i);
    stby <= 1'b0;
    repeat (3) @(posedge mclk_i);
    stby <= 1'b1;
    repeat (2) @(posedge mclk_i);
    for (int i = 0; i < 256; i++)
      if (d == bpe_pkg::PR_0M || exp_a[i] > lim(d))
        exp_v[i] = 1'b0;
    $display("test standby %0d done", d);
  endtask

  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    foreach (exp_v[i])
      exp_v[i] = 1'b0;
    @(posedge mclk_i);
    `CHK("oe reset", 1'b0, oe)
    `CHK("wait reset", 1'b1, wait_n)
    `CHK("adq reset", 32'h0000_0000, adq_out)
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Generous ceiling: a burst takes about twenty cycles
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    int          s;
    int          n;
    logic        wr;
    logic [21:0] a;
    rst_n_i  = 1'b0;
    stby     = 1'b1;
    dens     = bpe_pkg::PR_64M;
    lat_code = 3'h4;
    s = $urandom(32'h0974_2ecb);
    do_reset();
    @(posedge mclk_i);
    foreach (codes[k]) begin
      run(1'b1, 22'h00_0015 + 22'(k * 8), codes[k], 8);
      run(1'b0, 22'h00_0015 + 22'(k * 8), codes[k], 8);
    end
    $display("test latency done");
    run(1'b1, 22'h1f_fff9, 3'h4, 3);
    run(1'b0, 22'h1f_fff9, 3'h4, 1);
    run(1'b0, 22'h1f_fff9, 3'h6, 8);
    $display("test termination done");
    for (int k = 0; k < 80; k++) begin
      wr = 1'($urandom_range(1));
      n  = ($urandom_range(3) != 0) ? 8 : $urandom_range(7, 1);
      if (wq.size() > 0 && $urandom_range(1) == 1)
        a = wq[$urandom_range(wq.size() - 1)];
      else
        a = 22'($urandom);
      run(wr, a, codes[$urandom_range(4)], n);
      if (wr)
        wq.push_back(a);
    end
    $display("test random done");
    foreach (dcodes[d]) begin
      repeat (4) begin
        a = 22'($urandom);
        run(1'b1, a, 3'h5, 8);
        wq.push_back(a);
      end
      standby(dcodes[d]);
      for (int k = wq.size() - 6; k < wq.size(); k++)
        run(1'b0, wq[k], 3'h6, 8);
    end
    do_reset();
    run(1'b0, wq[0], 3'h4, 8);
    $display("test reset done");
    summarize();
  end
endmodule
